/* design/rps_top.sv */
// Remappable pin select crossbar with key-protected write lock
`timescale 1ns/1ps
`default_nettype none
module rps_top #(
  parameter int NUM_PINS = rps_pkg::NUM_PINS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Oscillator control low byte write port
  input wire logic osc_wr,
  input wire logic [7:0] osc_wdata,
  // Fuse word bits
  input wire logic [7:0] oscillator_fuse_word,
  // Mapping write ports
  input wire logic in_sel_wr,
  input wire logic [3:0] in_sel_idx,
  input wire logic [rps_pkg::FIELD_W-1:0] in_sel_data,
  input wire logic out_sel_wr,
  input wire logic [3:0] out_sel_idx,
  input wire logic [rps_pkg::FIELD_W-1:0] out_sel_data,
  // Status
  output logic map_write_lock,
  output logic cfg_mismatch_reset,
  output logic [rps_pkg::NUM_IN*rps_pkg::FIELD_W-1:0] input_select_regs,
  output logic [NUM_PINS*rps_pkg::FIELD_W-1:0] output_select_regs,
  // Remappable pins
  input wire logic [NUM_PINS-1:0] remappable_pin,
  // Port logic per pin
  input wire logic [NUM_PINS-1:0] port_out,
  input wire logic [NUM_PINS-1:0] port_oe,
  // Peripheral outputs
  input wire logic uart_transmit_out,
  input wire logic uart_request_to_send_out,
  input wire logic spi_data_out,
  input wire logic spi_clock_out,
  input wire logic spi_select_out,
  input wire logic compare_out_one,
  input wire logic compare_out_two,
  // Analog selects; a set bit keeps the pin on port_out with its driver off
  input wire logic [NUM_PINS-1:0] analog_sel,
  // Pin drive
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  // Peripheral inputs
  output logic ext_irq_one_in,
  output logic ext_irq_two_in,
  output logic timer_two_clock_in,
  output logic timer_three_clock_in,
  output logic capture_one_in,
  output logic capture_two_in,
  output logic capture_seven_in,
  output logic capture_eight_in,
  output logic compare_fault_a_in,
  output logic uart_receive_in,
  output logic uart_clear_to_send_in,
  output logic spi_data_in,
  output logic spi_clock_in,
  output logic spi_select_in
);
  localparam int FW = rps_pkg::FIELD_W;
  localparam int NI = rps_pkg::NUM_IN;

  // Elaboration checks: the 4-bit write indexes reach at most 16 pins and 16 inputs
  if (NUM_PINS < 1 || NUM_PINS > rps_pkg::NUM_PINS) begin : g_bad_pin_count
    $error("NUM_PINS must be 1 to 16");
  end
  if (rps_pkg::NUM_IN > 16) begin : g_bad_input_count
    $error("NUM_IN must not exceed 16");
  end

  // Select one pin by a 5-bit field; codes past the pin count read low
  function automatic logic pick_pin(input logic [NUM_PINS-1:0] pins,
                                    input logic [FW-1:0] sel);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sel == FW'(i)) begin
        r = pins[i];
      end
    end
    return r;
  endfunction : pick_pin

  // Peripheral output chosen by a pin output code
  function automatic logic pick_periph(input logic [FW-1:0] code, input logic [6:0] po);
    logic r;
    r = 1'b0;
    case (code)
      rps_pkg::OUT_UTX: r = po[0];
      rps_pkg::OUT_URTS: r = po[1];
      rps_pkg::OUT_SDO: r = po[2];
      rps_pkg::OUT_SCK: r = po[3];
      rps_pkg::OUT_SS: r = po[4];
      rps_pkg::OUT_CMP1: r = po[5];
      rps_pkg::OUT_CMP2: r = po[6];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_periph

  // Synchronised pins
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;

  // Lock and key state
  rps_pkg::rps_key_e key_st;
  rps_pkg::rps_key_e next_key_st;
  logic next_lock;
  logic lock_was_set;
  logic next_lock_was_set;
  logic [7:0] fuse_meta;
  logic [7:0] fuse_q;
  logic one_shot_lock_fuse;

  // Mapping storage
  logic [FW-1:0] in_map [NI];
  logic [FW-1:0] out_map [NUM_PINS];
  logic [FW-1:0] next_in_map [NI];
  logic [FW-1:0] next_out_map [NUM_PINS];
  logic map_wr_ok;

  // Routing next values
  logic [NI-1:0] next_periph_in;
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_pin_oe;
  logic [6:0] periph_out;

  rps_map_if map_bus();

  assign periph_out = {compare_out_two, compare_out_one, spi_select_out, spi_clock_out,
                       spi_data_out, uart_request_to_send_out, uart_transmit_out};
  assign one_shot_lock_fuse = fuse_q[rps_pkg::FUSE_ONE_SHOT_BIT];

  // Two-flop pin synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= remappable_pin;
      pin_sync <= pin_meta;
    end
  end

  // Key sequence and lock bit next values
  always_comb begin
    next_key_st = key_st;
    next_lock = map_write_lock;
    next_lock_was_set = lock_was_set;
    if (osc_wr) begin
      unique case (key_st)
        rps_pkg::RPS_KEY_IDLE: begin
          next_key_st = (osc_wdata == rps_pkg::KEY_FIRST) ? rps_pkg::RPS_KEY_ONE
                                                          : rps_pkg::RPS_KEY_IDLE;
        end
        rps_pkg::RPS_KEY_ONE: begin
          next_key_st = (osc_wdata == rps_pkg::KEY_SECOND) ? rps_pkg::RPS_KEY_OPEN
                                                           : rps_pkg::RPS_KEY_IDLE;
        end
        rps_pkg::RPS_KEY_OPEN: begin
          next_key_st = rps_pkg::RPS_KEY_IDLE;
          // Clearing refused once set when the one-shot fuse is set
          if (osc_wdata[rps_pkg::LOCK_BIT] ||
              !(one_shot_lock_fuse && lock_was_set)) begin
            next_lock = osc_wdata[rps_pkg::LOCK_BIT];
          end
        end
        default: next_key_st = rps_pkg::RPS_KEY_IDLE;
      endcase
    end
    if (next_lock) begin
      next_lock_was_set = 1'b1;
    end
  end

  // Lock state registers
  // Fuse word is a level from outside the clock domain, so it passes two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      key_st <= rps_pkg::RPS_KEY_IDLE;
      map_write_lock <= rps_pkg::LOCK_RESET;
      lock_was_set <= 1'b0;
      fuse_meta <= 8'hff;
      fuse_q <= 8'hff;
    end else begin
      key_st <= next_key_st;
      map_write_lock <= next_lock;
      lock_was_set <= next_lock_was_set;
      fuse_meta <= oscillator_fuse_word;
      fuse_q <= fuse_meta;
    end
  end

  // Mapping writes, silently dropped while locked
  always_comb begin
    map_wr_ok = !map_write_lock && (in_sel_wr || out_sel_wr);
    for (int i = 0; i < NI; i++) begin
      next_in_map[i] = in_map[i];
      if (!map_write_lock && in_sel_wr && in_sel_idx == 4'(i)) begin
        next_in_map[i] = in_sel_data;
      end
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      next_out_map[p] = out_map[p];
      if (!map_write_lock && out_sel_wr && out_sel_idx == 4'(p)) begin
        next_out_map[p] = out_sel_data;
      end
    end
  end

  // Mapping registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NI; i++) begin
        in_map[i] <= rps_pkg::MAP_RESET;
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        out_map[p] <= rps_pkg::MAP_RESET;
      end
    end else begin
      in_map <= next_in_map;
      out_map <= next_out_map;
    end
  end

  // Flatten mapping for status and shadow checker
  always_comb begin
    for (int i = 0; i < NI; i++) begin
      map_bus.in_map[i*FW +: FW] = in_map[i];
      map_bus.wr_in_map[i*FW +: FW] = next_in_map[i];
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      map_bus.out_map[p*FW +: FW] = out_map[p];
      map_bus.wr_out_map[p*FW +: FW] = next_out_map[p];
    end
    map_bus.wr_ok = map_wr_ok;
  end

  rps_shadow u_shadow (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .map(map_bus.monitor),
    .mismatch(cfg_mismatch_reset)
  );

  // Routing next values
  always_comb begin
    for (int i = 0; i < NI; i++) begin
      next_periph_in[i] = pick_pin(pin_sync, in_map[i]);
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      if (analog_sel[p] || out_map[p] == rps_pkg::OUT_NULL) begin
        next_pin_out[p] = port_out[p];
        next_pin_oe[p] = port_oe[p] && !analog_sel[p];
      end else begin
        next_pin_out[p] = pick_periph(out_map[p], periph_out);
        next_pin_oe[p] = 1'b1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out <= '0;
      pin_oe <= '0;
      input_select_regs <= '0;
      output_select_regs <= '0;
      // Peripheral inputs held low in reset
      ext_irq_one_in <= 1'b0;
      ext_irq_two_in <= 1'b0;
      timer_two_clock_in <= 1'b0;
      timer_three_clock_in <= 1'b0;
      capture_one_in <= 1'b0;
      capture_two_in <= 1'b0;
      capture_seven_in <= 1'b0;
      capture_eight_in <= 1'b0;
      compare_fault_a_in <= 1'b0;
      uart_receive_in <= 1'b0;
      uart_clear_to_send_in <= 1'b0;
      spi_data_in <= 1'b0;
      spi_clock_in <= 1'b0;
      spi_select_in <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      input_select_regs <= map_bus.in_map;
      output_select_regs <= map_bus.out_map;
      // Each peripheral input takes the pin chosen by its own field
      ext_irq_one_in <= next_periph_in[rps_pkg::IN_IRQ1];
      ext_irq_two_in <= next_periph_in[rps_pkg::IN_IRQ2];
      timer_two_clock_in <= next_periph_in[rps_pkg::IN_TIMER_TWO_CLOCK_IN];
      timer_three_clock_in <= next_periph_in[rps_pkg::IN_TIMER_THREE_CLOCK_IN];
      capture_one_in <= next_periph_in[rps_pkg::IN_CAP1];
      capture_two_in <= next_periph_in[rps_pkg::IN_CAP2];
      capture_seven_in <= next_periph_in[rps_pkg::IN_CAP7];
      capture_eight_in <= next_periph_in[rps_pkg::IN_CAP8];
      compare_fault_a_in <= next_periph_in[rps_pkg::IN_CFLT];
      uart_receive_in <= next_periph_in[rps_pkg::IN_URX];
      uart_clear_to_send_in <= next_periph_in[rps_pkg::IN_UCTS];
      spi_data_in <= next_periph_in[rps_pkg::IN_SDI];
      spi_clock_in <= next_periph_in[rps_pkg::IN_SCK];
      spi_select_in <= next_periph_in[rps_pkg::IN_SS];
    end
  end
endmodule : rps_top
`default_nettype wire

/* design/rps_pkg.sv */
// Constants and types for the remappable pin select crossbar
package rps_pkg;
  localparam int FIELD_W = 5;
  localparam int NUM_IN = 14;
  localparam int NUM_PINS = 16;
  localparam int LOCK_BIT = 6;
  localparam int FUSE_ONE_SHOT_BIT = 5;
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;
  localparam logic [FIELD_W-1:0] MAP_RESET = 5'h00;
  localparam logic LOCK_RESET = 1'b0;
  // Input function indexes
  localparam int IN_IRQ1 = 0;
  localparam int IN_IRQ2 = 1;
  localparam int IN_TIMER_TWO_CLOCK_IN = 2;
  localparam int IN_TIMER_THREE_CLOCK_IN = 3;
  localparam int IN_CAP1 = 4;
  localparam int IN_CAP2 = 5;
  localparam int IN_CAP7 = 6;
  localparam int IN_CAP8 = 7;
  localparam int IN_CFLT = 8;
  localparam int IN_URX = 9;
  localparam int IN_UCTS = 10;
  localparam int IN_SDI = 11;
  localparam int IN_SCK = 12;
  localparam int IN_SS = 13;
  // Output codes
  localparam logic [FIELD_W-1:0] OUT_NULL = 5'h00;
  localparam logic [FIELD_W-1:0] OUT_UTX = 5'h03;
  localparam logic [FIELD_W-1:0] OUT_URTS = 5'h04;
  localparam logic [FIELD_W-1:0] OUT_SDO = 5'h07;
  localparam logic [FIELD_W-1:0] OUT_SCK = 5'h08;
  localparam logic [FIELD_W-1:0] OUT_SS = 5'h09;
  localparam logic [FIELD_W-1:0] OUT_CMP1 = 5'h12;
  localparam logic [FIELD_W-1:0] OUT_CMP2 = 5'h13;
  // Key sequence states
  typedef enum logic [1:0] {
    RPS_KEY_IDLE = 2'b00,
    RPS_KEY_ONE = 2'b01,
    RPS_KEY_OPEN = 2'b11
  } rps_key_e;
endpackage : rps_pkg

/* design/rps_map_if.sv */
// Interface carrying mapping contents and write events to the shadow checker
`timescale 1ns/1ps
`default_nettype none
interface rps_map_if;
  logic [rps_pkg::NUM_IN*rps_pkg::FIELD_W-1:0] in_map;
  logic [rps_pkg::NUM_PINS*rps_pkg::FIELD_W-1:0] out_map;
  logic wr_ok;
  logic [rps_pkg::NUM_IN*rps_pkg::FIELD_W-1:0] wr_in_map;
  logic [rps_pkg::NUM_PINS*rps_pkg::FIELD_W-1:0] wr_out_map;
  modport owner (output in_map, output out_map, output wr_ok, output wr_in_map,
                 output wr_out_map);
  modport monitor (input in_map, input out_map, input wr_ok, input wr_in_map,
                   input wr_out_map);
endinterface : rps_map_if
`default_nettype wire

/* design/rps_shadow.sv */
// Shadow copy of the mapping registers with continuous mismatch detection
`timescale 1ns/1ps
`default_nettype none
module rps_shadow (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Mapping contents
  rps_map_if.monitor map,
  // Mismatch result
  output logic mismatch
);
  logic [rps_pkg::NUM_IN*rps_pkg::FIELD_W-1:0] shd_in;
  logic [rps_pkg::NUM_PINS*rps_pkg::FIELD_W-1:0] shd_out;
  logic [rps_pkg::NUM_IN*rps_pkg::FIELD_W-1:0] next_shd_in;
  logic [rps_pkg::NUM_PINS*rps_pkg::FIELD_W-1:0] next_shd_out;
  logic next_mismatch;

  // Shadow follows legitimate writes only; compare live copy each cycle
  always_comb begin
    next_shd_in = map.wr_ok ? map.wr_in_map : shd_in;
    next_shd_out = map.wr_ok ? map.wr_out_map : shd_out;
    next_mismatch = (map.in_map != shd_in) || (map.out_map != shd_out);
  end

  // Register shadow state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shd_in <= '0;
      shd_out <= '0;
      mismatch <= 1'b0;
    end else begin
      shd_in <= next_shd_in;
      shd_out <= next_shd_out;
      mismatch <= next_mismatch;
    end
  end
endmodule : rps_shadow
`default_nettype wire

/* tb/rps_chk.sv */
// Assertion checker for the pin select crossbar
`timescale 1ns/1ps
`default_nettype none
module rps_chk #(
  parameter int NUM_PINS = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Write ports
  input wire logic osc_wr,
  input wire logic [7:0] osc_wdata,
  input wire logic [7:0] oscillator_fuse_word,
  input wire logic in_sel_wr,
  input wire logic [3:0] in_sel_idx,
  input wire logic [4:0] in_sel_data,
  input wire logic out_sel_wr,
  input wire logic [3:0] out_sel_idx,
  input wire logic [4:0] out_sel_data,
  input wire logic [NUM_PINS-1:0] analog_sel,
  // Results
  input wire logic map_write_lock,
  input wire logic cfg_mismatch_reset,
  input wire logic [69:0] input_select_regs,
  input wire logic [NUM_PINS*5-1:0] output_select_regs,
  input wire logic [NUM_PINS-1:0] pin_oe
);
  // All checks run on the system clock outside reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  lock_hold_a: assert property (!$past(osc_wr) |-> $stable(map_write_lock))
    else $error("lock moved without a control write");
  lock_key_a: assert property ($rose(map_write_lock) |-> $past(osc_wdata[6]))
    else $error("lock set without bit 6 written");
  in_locked_a: assert property (in_sel_wr && map_write_lock |=> ##1 $stable(input_select_regs))
    else $error("input map changed while locked");
  out_locked_a: assert property (out_sel_wr && map_write_lock |=> ##1
    $stable(output_select_regs)) else $error("output map changed while locked");
  in_write_a: assert property (in_sel_wr && !map_write_lock && in_sel_idx < 14 |-> ##2
    input_select_regs[$past(in_sel_idx, 2)*5 +: 5] == $past(in_sel_data, 2))
    else $error("input field not written");
  out_write_a: assert property (out_sel_wr && !map_write_lock |-> ##2
    output_select_regs[$past(out_sel_idx, 2)*5 +: 5] == $past(out_sel_data, 2))
    else $error("output code not written");
  no_mismatch_a: assert property (!cfg_mismatch_reset)
    else $error("mismatch reset after legal writes");
  fuse_hold_a: assert property (map_write_lock && oscillator_fuse_word[5] |=> map_write_lock)
    else $error("lock cleared under one-shot fuse");
  analog_a: assert property (analog_sel[0] |=> !pin_oe[0])
    else $error("analog pin driven");
  // Main scenarios reached
  lock_set_c: cover property ($rose(map_write_lock));
  refused_c: cover property (in_sel_wr && map_write_lock);
  analog_c: cover property (analog_sel[0]);
endmodule : rps_chk

bind rps_top rps_chk #(.NUM_PINS(NUM_PINS)) u_chk (
  .clk_sys, .rstn, .osc_wr, .osc_wdata, .oscillator_fuse_word, .in_sel_wr, .in_sel_idx,
  .in_sel_data, .out_sel_wr, .out_sel_idx, .out_sel_data, .analog_sel, .map_write_lock,
  .cfg_mismatch_reset, .input_select_regs, .output_select_regs, .pin_oe
);
`default_nettype wire

/* tb/rps_far_model.sv */
// Far side model: peripheral outputs and remappable pin levels
`timescale 1ns/1ps
`default_nettype none
module rps_far_model (
  // Levels asked for by the bench
  input wire logic [15:0] pin_lvl,
  input wire logic [6:0] out_lvl,
  // Driven levels
  output logic [15:0] remappable_pin,
  output logic [6:0] periph
);
  // Pins and peripherals hold the asked levels
  assign remappable_pin = pin_lvl;
  assign periph = out_lvl;
endmodule : rps_far_model
`default_nettype wire

/* tb/tb_rps_top.sv */
// Self-checking bench for the pin select crossbar
`timescale 1ns/1ps
`default_nettype none
module tb_rps_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic osc_wr = 1'b0, in_sel_wr = 1'b0, out_sel_wr = 1'b0;
  logic [7:0] osc_wdata = 8'h00, oscillator_fuse_word = 8'h00;
  logic [3:0] in_sel_idx = 4'h0, out_sel_idx = 4'h0;
  logic [4:0] in_sel_data = 5'h00, out_sel_data = 5'h00;
  logic [15:0] pin_lvl = 16'h0000, port_out = 16'h0f0f, port_oe = 16'h00ff;
  logic [15:0] analog_sel = 16'h0000;
  logic [6:0] out_lvl = 7'h00;
  logic [15:0] remappable_pin, pin_out, pin_oe;
  logic [6:0] periph;
  logic [13:0] pin_in;
  logic map_write_lock, cfg_mismatch_reset;
  logic [69:0] input_select_regs;
  logic [79:0] output_select_regs;
  int failures = 0;
  int n_compared = 0;
  // System clock
  always #2 clk_sys = ~clk_sys;
  rps_far_model far (.pin_lvl, .out_lvl, .remappable_pin, .periph);
  rps_top #(.NUM_PINS(16)) dut (
    .clk_sys, .rstn, .osc_wr, .osc_wdata, .oscillator_fuse_word, .in_sel_wr, .in_sel_idx,
    .in_sel_data, .out_sel_wr, .out_sel_idx, .out_sel_data, .map_write_lock,
    .cfg_mismatch_reset, .input_select_regs, .output_select_regs, .remappable_pin,
    .port_out, .port_oe, .analog_sel, .pin_out, .pin_oe,
    .uart_transmit_out(periph[0]), .uart_request_to_send_out(periph[1]),
    .spi_data_out(periph[2]), .spi_clock_out(periph[3]), .spi_select_out(periph[4]),
    .compare_out_one(periph[5]), .compare_out_two(periph[6]),
    .ext_irq_one_in(pin_in[0]), .ext_irq_two_in(pin_in[1]), .timer_two_clock_in(pin_in[2]),
    .timer_three_clock_in(pin_in[3]), .capture_one_in(pin_in[4]), .capture_two_in(pin_in[5]),
    .capture_seven_in(pin_in[6]), .capture_eight_in(pin_in[7]),
    .compare_fault_a_in(pin_in[8]), .uart_receive_in(pin_in[9]),
    .uart_clear_to_send_in(pin_in[10]), .spi_data_in(pin_in[11]),
    .spi_clock_in(pin_in[12]), .spi_select_in(pin_in[13])
  );
  // Compare and count
  task automatic chk(input string what, input logic [79:0] got, input logic [79:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle strobe: kind 0 control byte, 1 input field, 2 output code
  task automatic strobe(input int kind, input logic [7:0] d, input logic [3:0] idx);
    @(negedge clk_sys);
    osc_wr = (kind == 0);
    in_sel_wr = (kind == 1);
    out_sel_wr = (kind == 2);
    osc_wdata = d;
    in_sel_idx = idx;
    out_sel_idx = idx;
    in_sel_data = d[4:0];
    out_sel_data = d[4:0];
    @(negedge clk_sys);
    osc_wr = 1'b0;
    in_sel_wr = 1'b0;
    out_sel_wr = 1'b0;
  endtask : strobe
  // Key pair then the lock value
  task automatic key(input logic [7:0] v);
    strobe(0, 8'h46, 4'h0);
    strobe(0, 8'h57, 4'h0);
    strobe(0, v, 4'h0);
    repeat (2) @(negedge clk_sys);
  endtask : key
  task automatic t_reset;
    chk("lock", map_write_lock, 0);
    chk("in", input_select_regs, 0);
    chk("out", output_select_regs, 0);
    repeat (3) @(negedge clk_sys);
    chk("pin", pin_out, port_out);
    chk("oe", pin_oe, port_oe);
  endtask : t_reset
  task automatic t_inputs;
    logic [69:0] exp_regs;
    logic [13:0] exp_in;
    exp_regs = '0;
    for (int i = 0; i < 14; i++) begin
      strobe(1, 8'((i * 5) % 16), 4'(i));
      exp_regs[i*5 +: 5] = 5'((i * 5) % 16);
    end
    @(negedge clk_sys);
    chk("in", input_select_regs, exp_regs);
    for (int k = 0; k < 2; k++) begin
      pin_lvl = k ? 16'h5a3c : 16'ha5c3;
      repeat (5) @(negedge clk_sys);
      for (int i = 0; i < 14; i++) exp_in[i] = pin_lvl[(i * 5) % 16];
      chk("pin_in", pin_in, exp_in);
    end
  endtask : t_inputs
  task automatic t_outputs;
    logic [4:0] code [8] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12, 5'h13};
    logic [15:0] exp_o, exp_e;
    for (int p = 0; p < 16; p++) strobe(2, 8'(code[p % 8]), 4'(p));
    for (int k = 0; k < 2; k++) begin
      out_lvl = k ? 7'h2c : 7'h53;
      repeat (3) @(negedge clk_sys);
      for (int p = 0; p < 16; p++) begin
        exp_o[p] = (p % 8 == 0) ? port_out[p] : out_lvl[p % 8 - 1];
        exp_e[p] = (p % 8 == 0) ? port_oe[p] : 1'b1;
      end
      chk("pin", pin_out, exp_o);
      chk("oe", pin_oe, exp_e);
    end
  endtask : t_outputs
  task automatic t_lock;
    key(8'h40);
    chk("lock", map_write_lock, 1);
    strobe(1, 8'h09, 4'h0);
    strobe(2, 8'h13, 4'h1);
    repeat (2) @(negedge clk_sys);
    chk("in", input_select_regs[4:0], 0);
    chk("out", output_select_regs[9:5], 5'h03);
    // Broken key orders leave the lock alone
    strobe(0, 8'h46, 4'h0);
    strobe(0, 8'h00, 4'h0);
    strobe(0, 8'h57, 4'h0);
    strobe(0, 8'h00, 4'h0);
    repeat (2) @(negedge clk_sys);
    chk("lock", map_write_lock, 1);
    key(8'h00);
    chk("lock", map_write_lock, 0);
    strobe(1, 8'h0f, 4'h0);
    strobe(1, 8'h0e, 4'hd);
    repeat (2) @(negedge clk_sys);
    chk("in", {input_select_regs[69:65], input_select_regs[4:0]}, 10'h1cf);
    chk("mismatch", cfg_mismatch_reset, 0);
  endtask : t_lock
  task automatic t_analog;
    analog_sel = 16'h0203;
    repeat (3) @(negedge clk_sys);
    chk("oe", pin_oe & 16'h0203, 0);
    analog_sel = 16'h0000;
  endtask : t_analog
  task automatic t_fuse;
    oscillator_fuse_word = 8'h20;
    key(8'h40);
    key(8'h00);
    chk("lock", map_write_lock, 1);
    strobe(2, 8'h07, 4'h2);
    repeat (2) @(negedge clk_sys);
    chk("out", output_select_regs[14:10], 5'h04);
  endtask : t_fuse
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset;
    t_inputs;
    t_outputs;
    t_lock;
    t_analog;
    t_fuse;
    tally_and_finish;
  end
  // Watchdog, about thirty times the expected run
  initial begin
    #20000;
    failures++;
    tally_and_finish;
  end
endmodule : tb_rps_top
`default_nettype wire
